/* File: hw/tcs_defines.svh */
// offsets, field positions, reset values and timing figures of the sequencer
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

`define TCS_IDX_RESULT   2'h0
`define TCS_IDX_CONFIG   2'h1
`define TCS_IDX_UPPER    2'h2
`define TCS_IDX_LOWER    2'h3

`define TCS_CFG_DRDY     13
`define TCS_CFG_MOD_HI   11
`define TCS_CFG_MOD_LO   10
`define TCS_CFG_CONV_HI  9
`define TCS_CFG_CONV_LO  7
`define TCS_CFG_AVG_HI   6
`define TCS_CFG_AVG_LO   5

`define TCS_RESULT_RST   16'h8000
`define TCS_UPPER_RST    16'h6000
`define TCS_LOWER_RST    16'h8000
`define TCS_CONV_RST     3'h4
`define TCS_AVG_RST      2'h1

`define TCS_CLK_MHZ      50
`define TCS_PWRUP_US     1500
`define TCS_CONV_US      15500
`define TCS_TMO_US       30000

`endif

/* File: hw/tcs_pkg.sv */
// types shared by the sequencer files
package tcs_pkg;
   typedef enum logic [1:0] {
      TCS_MODE_CONT = 2'h0,
      TCS_MODE_HALT = 2'h1,
      TCS_MODE_ONCE = 2'h2,
      TCS_MODE_ALT  = 2'h3
   } tcs_mode_t;

   typedef enum logic [1:0] {
      TCS_ST_PWRUP,
      TCS_ST_HALT,
      TCS_ST_ACTIVE,
      TCS_ST_STANDBY
   } tcs_state_t;
endpackage

/* File: hw/tcs_averager.sv */
// accumulates signed samples and produces their rounded mean
`timescale 1ns/1ps
module tcs_averager (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               clear,
   input  wire logic               add,
   input  wire logic signed [15:0] sample,
   input  wire logic [2:0]         shift,
   output logic signed [15:0]      mean
);
   logic signed [23:0] acc;
   logic signed [23:0] next_acc;
   logic signed [23:0] rounded;
   logic signed [23:0] half;

   always_comb begin
      next_acc = acc;
      if (clear) begin
         next_acc = 24'sh0;
      end else if (add) begin
         next_acc = acc + 24'(sample);
      end
   end

   // round half up before the arithmetic shift
   always_comb begin
      half = (shift == 3'h0) ? 24'sh0 : (24'sh1 <<< (shift - 3'h1));
      rounded = (acc + half) >>> shift;
      mean = rounded[15:0];
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc <= 24'sh0;
      end else begin
         acc <= next_acc;
      end
   end
endmodule

/* File: hw/tcs_sequencer.sv */
// conversion sequencer, result and limit registers, bus stall watchdog
// How it works
// - after power-up, wait the power-up interval before the first conversion
// - result reads 8000 hex until the first conversion cycle completes
// - each finished conversion cycle writes its result to the result register
// - result is 16-bit two's complement, one lsb is 7.8125 millidegrees
// - both limit registers hold the same 16-bit format, host writes so
// - the two-bit mode field chooses the conversion mode
// - continuous cycles are active conversion then standby
// - cycle time and averaging fields set active and standby lengths
// - result refresh follows the cycle period, once per cycle
// - averaging runs n conversions, accumulates, publishes only the mean
// - one conversion takes 15.5 ms, active time is that times n
// - reset defaults give eight averages and a one second cycle
// - stalled serial clock releases the data line after 20 to 40 ms
// - a stored strap makes the device leave power-up in shutdown
// - mode 00 repeats conversion cycles without end
// - writing mode 01 aborts any conversion and enters shutdown, except when written in a publish cycle
// - mode 10 in shutdown runs one active-only conversion cycle, then shutdown
// - done flag sets at each result, clears on config or result read
`timescale 1ns/1ps
`include "tcs_defines.svh"
module tcs_sequencer #(
   parameter int CYC_PER_US = `TCS_CLK_MHZ,
   parameter int PWRUP_CYC  = `TCS_PWRUP_US * `TCS_CLK_MHZ,
   parameter int CONV_CYC   = `TCS_CONV_US * `TCS_CLK_MHZ,
   parameter int TMO_CYC    = `TCS_TMO_US * `TCS_CLK_MHZ
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        halt_strap,
   input  wire logic [15:0] adc_sample,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [1:0]  reg_idx,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   output logic             data_ready,
   input  wire logic        scl,
   input  wire logic        bus_active,
   input  wire logic        sda_drive_low,
   output logic             sda_o,
   output logic             sda_oe_n
);
   tcs_pkg::tcs_state_t state;
   tcs_pkg::tcs_state_t next_state;
   tcs_pkg::tcs_mode_t  mode;
   tcs_pkg::tcs_mode_t  next_mode;
   logic [2:0]  cyc_sel;
   logic [2:0]  next_cyc_sel;
   logic [1:0]  avg_sel;
   logic [1:0]  next_avg_sel;
   logic [15:0] result;
   logic [15:0] next_result;
   logic [15:0] upper;
   logic [15:0] next_upper;
   logic [15:0] lower;
   logic [15:0] next_lower;
   logic [15:0] next_rdata;
   logic        next_ready;
   logic [31:0] tmr;
   logic [31:0] next_tmr;
   logic [31:0] cyc_tmr;
   logic [31:0] next_cyc_tmr;
   logic [6:0]  n_done;
   logic [6:0]  next_n_done;
   logic        publish;
   logic        conv_end;
   logic        acc_clear;
   logic [6:0]  n_avg;
   logic [2:0]  avg_shift;
   logic [31:0] cycle_len;
   logic [15:0] mean;
   logic [1:0]  strap_sync;
   logic [2:0]  scl_sync;
   logic        scl_edge;
   logic [31:0] wd;
   logic [31:0] next_wd;
   logic        timed_out;
   logic        next_timed_out;
   logic        wr_cfg;

   // sample counts and cycle times per code, reset codes give 8 and 1 s
   always_comb begin
      case (avg_sel)
         2'h0: begin n_avg = 7'h01; avg_shift = 3'h0; end
         2'h1: begin n_avg = 7'h08; avg_shift = 3'h3; end
         2'h2: begin n_avg = 7'h20; avg_shift = 3'h5; end
         default: begin n_avg = 7'h40; avg_shift = 3'h6; end
      endcase
      case (cyc_sel)
         3'h0: cycle_len = 32'(`TCS_CONV_US * CYC_PER_US);
         3'h1: cycle_len = 32'(125000 * CYC_PER_US);
         3'h2: cycle_len = 32'(250000 * CYC_PER_US);
         3'h3: cycle_len = 32'(500000 * CYC_PER_US);
         3'h4: cycle_len = 32'(1000000 * CYC_PER_US);
         3'h5: cycle_len = 32'(4000000 * CYC_PER_US);
         3'h6: cycle_len = 32'(8000000 * CYC_PER_US);
         default: cycle_len = 32'(16000000 * CYC_PER_US);
      endcase
   end

   tcs_averager u_avg (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .clear   (acc_clear),
      .add     (conv_end),
      .sample  (adc_sample),
      .shift   (avg_shift),
      .mean    (mean)
   );

   assign wr_cfg = reg_wr && (reg_idx == `TCS_IDX_CONFIG);

   // sequencing of power-up, shutdown, active and standby
   always_comb begin
      next_state   = state;
      next_mode    = mode;
      next_tmr     = tmr + 32'h1;
      next_cyc_tmr = cyc_tmr + 32'h1;
      next_n_done  = n_done;
      conv_end     = 1'b0;
      publish      = 1'b0;
      acc_clear    = 1'b0;
      if (wr_cfg) begin
         case (reg_wdata[`TCS_CFG_MOD_HI:`TCS_CFG_MOD_LO])
            2'h2: if (state == tcs_pkg::TCS_ST_HALT) begin
               next_mode = tcs_pkg::TCS_MODE_ONCE;
            end
            2'h1: next_mode = tcs_pkg::TCS_MODE_HALT;
            default: next_mode = tcs_pkg::TCS_MODE_CONT;
         endcase
      end
      case (state)
         tcs_pkg::TCS_ST_PWRUP: begin
            if (tmr >= 32'(PWRUP_CYC - 1)) begin
               next_tmr = 32'h0;
               next_cyc_tmr = 32'h0;
               acc_clear = 1'b1;
               next_n_done = 7'h0;
               // a shutdown written during power-up takes effect here
               if (strap_sync[1] ||
                   next_mode == tcs_pkg::TCS_MODE_HALT) begin
                  next_mode = tcs_pkg::TCS_MODE_HALT;
                  next_state = tcs_pkg::TCS_ST_HALT;
               end else begin
                  next_state = tcs_pkg::TCS_ST_ACTIVE;
               end
            end
         end
         tcs_pkg::TCS_ST_HALT: begin
            next_tmr = 32'h0;
            next_cyc_tmr = 32'h0;
            acc_clear = 1'b1;
            next_n_done = 7'h0;
            if (mode != tcs_pkg::TCS_MODE_HALT) begin
               next_state = tcs_pkg::TCS_ST_ACTIVE;
            end
         end
         tcs_pkg::TCS_ST_ACTIVE: begin
            if (tmr >= 32'(CONV_CYC - 1)) begin
               conv_end = 1'b1;
               next_tmr = 32'h0;
               next_n_done = n_done + 7'h1;
               if (n_done + 7'h1 == n_avg) begin
                  next_state = tcs_pkg::TCS_ST_STANDBY;
               end
            end
         end
         tcs_pkg::TCS_ST_STANDBY: begin
            // the mean is settled one cycle after the last sample is added
            if (n_done != 7'h0) begin
               publish = 1'b1;
               acc_clear = 1'b1;
               next_n_done = 7'h0;
            end
            if (mode == tcs_pkg::TCS_MODE_ONCE) begin
               next_mode = tcs_pkg::TCS_MODE_HALT;
               next_state = tcs_pkg::TCS_ST_HALT;
            end else if (n_done == 7'h0 &&
                         cyc_tmr >= cycle_len - 32'h1) begin
               next_tmr = 32'h0;
               next_cyc_tmr = 32'h0;
               next_state = tcs_pkg::TCS_ST_ACTIVE;
            end
         end
         default: next_state = tcs_pkg::TCS_ST_PWRUP;
      endcase
      // abort wins over anything running except power-up and a publish cycle
      if (next_mode == tcs_pkg::TCS_MODE_HALT && mode != tcs_pkg::TCS_MODE_HALT
          && state != tcs_pkg::TCS_ST_PWRUP && !publish) begin
         next_state = tcs_pkg::TCS_ST_HALT;
      end
   end

   // register file and the done flag
   always_comb begin
      next_cyc_sel = cyc_sel;
      next_avg_sel = avg_sel;
      next_upper   = upper;
      next_lower   = lower;
      next_result  = result;
      next_ready   = data_ready;
      next_rdata   = reg_rdata;
      if (wr_cfg) begin
         next_cyc_sel = reg_wdata[`TCS_CFG_CONV_HI:`TCS_CFG_CONV_LO];
         next_avg_sel = reg_wdata[`TCS_CFG_AVG_HI:`TCS_CFG_AVG_LO];
      end
      if (reg_wr && reg_idx == `TCS_IDX_UPPER) next_upper = reg_wdata;
      if (reg_wr && reg_idx == `TCS_IDX_LOWER) next_lower = reg_wdata;
      if (reg_rd) begin
         case (reg_idx)
            `TCS_IDX_RESULT: next_rdata = result;
            `TCS_IDX_CONFIG: begin
               next_rdata = 16'h0000;
               next_rdata[`TCS_CFG_DRDY] = data_ready;
               next_rdata[`TCS_CFG_MOD_HI:`TCS_CFG_MOD_LO] = mode;
               next_rdata[`TCS_CFG_CONV_HI:`TCS_CFG_CONV_LO] = cyc_sel;
               next_rdata[`TCS_CFG_AVG_HI:`TCS_CFG_AVG_LO] = avg_sel;
            end
            `TCS_IDX_UPPER: next_rdata = upper;
            default: next_rdata = lower;
         endcase
         if (reg_idx == `TCS_IDX_RESULT || reg_idx == `TCS_IDX_CONFIG) begin
            next_ready = 1'b0;
         end
      end
      if (publish) begin
         next_result = mean;
         next_ready = 1'b1;
      end
   end

   // serial clock watchdog; scl_sync[0] feeds only scl_sync[1]
   assign scl_edge = scl_sync[2] ^ scl_sync[1];

   always_comb begin
      next_wd = wd + 32'h1;
      next_timed_out = timed_out;
      if (!bus_active) begin
         next_wd = 32'h0;
         next_timed_out = 1'b0;
      end else if (scl_edge) begin
         next_wd = 32'h0;
      end else if (wd >= 32'(TMO_CYC - 1)) begin
         next_wd = wd;
         next_timed_out = 1'b1;
      end
   end

   assign sda_o    = 1'b0;
   assign sda_oe_n = !(sda_drive_low && !timed_out);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state      <= tcs_pkg::TCS_ST_PWRUP;
         mode       <= tcs_pkg::TCS_MODE_CONT;
         cyc_sel    <= `TCS_CONV_RST;
         avg_sel    <= `TCS_AVG_RST;
         result     <= `TCS_RESULT_RST;
         upper      <= `TCS_UPPER_RST;
         lower      <= `TCS_LOWER_RST;
         reg_rdata  <= 16'h0000;
         data_ready <= 1'b0;
         tmr        <= 32'h0;
         cyc_tmr    <= 32'h0;
         n_done     <= 7'h0;
         strap_sync <= 2'h0;
         scl_sync   <= 3'h7;
         wd         <= 32'h0;
         timed_out  <= 1'b0;
      end else begin
         state      <= next_state;
         mode       <= next_mode;
         cyc_sel    <= next_cyc_sel;
         avg_sel    <= next_avg_sel;
         result     <= next_result;
         upper      <= next_upper;
         lower      <= next_lower;
         reg_rdata  <= next_rdata;
         data_ready <= next_ready;
         tmr        <= next_tmr;
         cyc_tmr    <= next_cyc_tmr;
         n_done     <= next_n_done;
         strap_sync <= {strap_sync[0], halt_strap};
         scl_sync   <= {scl_sync[1:0], scl};
         wd         <= next_wd;
         timed_out  <= next_timed_out;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_pwrup_wait: assert property (
      state == tcs_pkg::TCS_ST_PWRUP && tmr < 32'(PWRUP_CYC - 1)
      |=> state == tcs_pkg::TCS_ST_PWRUP)
      else $error("left power-up early");
   a_result_held: assert property (
      !publish |=> result == $past(result))
      else $error("result changed without a finished cycle");
   a_result_load: assert property (
      publish |=> result == $past(mean) && data_ready)
      else $error("result not loaded at end of cycle");
   a_ready_set: assert property (
      publish |=> data_ready)
      else $error("done flag not set");
   a_ready_clear: assert property (
      reg_rd && reg_idx == `TCS_IDX_RESULT && !publish |=> !data_ready)
      else $error("done flag not cleared by result read");
   a_halt_abort: assert property (
      wr_cfg && reg_wdata[`TCS_CFG_MOD_HI:`TCS_CFG_MOD_LO] == 2'h1
      && state == tcs_pkg::TCS_ST_ACTIVE |=> state == tcs_pkg::TCS_ST_HALT)
      else $error("shutdown write did not abort");
   a_once_return: assert property (
      mode == tcs_pkg::TCS_MODE_ONCE && publish
      |=> state == tcs_pkg::TCS_ST_HALT && mode == tcs_pkg::TCS_MODE_HALT)
      else $error("one-shot did not return to shutdown");
   a_conv_len: assert property (
      conv_end |=> tmr == 32'h0 ##1 tmr == 32'h1)
      else $error("conversion timer not restarted");
   a_avg_count: assert property (
      publish |-> n_done == n_avg)
      else $error("published before all samples");
   a_release: assert property (
      $rose(timed_out) |-> sda_oe_n && $past(bus_active)
      && $past(wd) >= 32'(TMO_CYC - 1))
      else $error("data line released off the timeout");

   c_cont_cycle: cover property (state == tcs_pkg::TCS_ST_STANDBY
      && next_state == tcs_pkg::TCS_ST_ACTIVE);
   c_one_shot: cover property (mode == tcs_pkg::TCS_MODE_ONCE && publish);
   c_timeout: cover property ($rose(timed_out));
endmodule

/* File: sim/tcs_host_model.sv */
// behavioural far side: transaction level, data pull and serial clock
`timescale 1ns/1ps
module tcs_host_model (
   input  wire logic start,
   input  wire logic stall,
   output logic      scl,
   output logic      bus_active,
   output logic      sda_drive_low
);
   assign bus_active    = start;
   // holds data low all through a transfer, the worst case for a stall
   assign sda_drive_low = start;
   // 160 ns clock, phase unrelated to clk_sys; idles high as if pulled up
   initial begin
      scl = 1'b1;
      #37;
      forever begin
         #80;
         if (!start)
            scl = 1'b1;
         else if (!stall)
            scl = ~scl;
      end
   end
endmodule

/* File: sim/tcs_sequencer_tb.sv */
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`include "tcs_defines.svh"
module tcs_sequencer_tb;
   localparam int CONV = 10;
   localparam int PWRUP = 20;
   localparam int AVG_N [4] = '{1, 8, 32, 64};
   logic        clk_sys;
   logic        rst_n;
   logic        halt_strap;
   logic [15:0] adc_sample;
   logic        reg_wr;
   logic        reg_rd;
   logic [1:0]  reg_idx;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        data_ready;
   logic        scl;
   logic        bus_active;
   logic        sda_drive_low;
   logic        sda_o;
   logic        sda_oe_n;
   logic        start;
   logic        stall;
   logic        rd_seen;
   logic [15:0] exp_q[$];
   logic [31:0] seed;
   logic [15:0] v;
   logic [15:0] w;
   int          mismatches;
   int          checks_done;
   int          cyc;
   int          t1;

   tcs_sequencer #(.CYC_PER_US(1), .PWRUP_CYC(PWRUP), .CONV_CYC(CONV),
                   .TMO_CYC(50)) u_tcs_sequencer (
      .clk_sys(clk_sys), .rst_n(rst_n), .halt_strap(halt_strap),
      .adc_sample(adc_sample), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .data_ready(data_ready), .scl(scl), .bus_active(bus_active),
      .sda_drive_low(sda_drive_low), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
   );
   tcs_host_model u_tcs_host_model (
      .start(start), .stall(stall), .scl(scl), .bus_active(bus_active),
      .sda_drive_low(sda_drive_low)
   );

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   task automatic cmp(input string what, input logic [15:0] e,
                      input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(input logic [1:0] i, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_idx <= i;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // expected word queued here, compared by the watcher below
   task automatic rd(input logic [1:0] i, input logic [15:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_idx <= i;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask

   task automatic wait_dr(input int lim);
      int n;
      n = 0;
      while (data_ready !== 1'b1 && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      if (rd_seen)
         cmp("read word", exp_q.pop_front(), reg_rdata);
      rd_seen <= reg_rd;
   end

   // run needs about 18000 cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      {rst_n, halt_strap, reg_wr, reg_rd, start, stall} = 6'h00;
      adc_sample = 16'h0000;
      reg_idx = 2'h0;
      reg_wdata = 16'h0000;
      seed = 32'h0000_0022;
      {mismatches, checks_done, cyc} = {32'h0, 32'h0, 32'h0};
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      t1 = cyc;
      v = rnd();
      adc_sample <= v;
      rd(`TCS_IDX_RESULT, `TCS_RESULT_RST);
      rd(`TCS_IDX_UPPER, `TCS_UPPER_RST);
      rd(`TCS_IDX_LOWER, `TCS_LOWER_RST);
      rd(`TCS_IDX_CONFIG, {6'h00, `TCS_CONV_RST, `TCS_AVG_RST, 5'h00});
      wr(`TCS_IDX_RESULT, 16'h1234);
      rd(`TCS_IDX_RESULT, `TCS_RESULT_RST);
      for (int i = 2; i < 4; i++) begin
         w = rnd();
         wr(2'(i), w);
         rd(2'(i), w);
      end
      wait_dr(200);
      cmp("power-up span", 16'h0001, 16'((cyc - t1) >= PWRUP + 8 * CONV
          && (cyc - t1) <= PWRUP + 8 * CONV + 8));
      cmp("done flag", 16'h0001, {15'h0000, data_ready});
      rd(`TCS_IDX_RESULT, v);
      rd(`TCS_IDX_CONFIG, 16'h0220);
      wr(`TCS_IDX_CONFIG, 16'h0620);
      for (int a = 0; a < 4; a++) begin
         v = rnd();
         adc_sample <= v;
         wr(`TCS_IDX_CONFIG, 16'h0A00 | 16'(a << 5));
         t1 = cyc;
         wait_dr(700);
         cmp("single span", 16'h0001, 16'((cyc - t1) >= AVG_N[a] * CONV
             && (cyc - t1) <= AVG_N[a] * CONV + 4));
         rd(`TCS_IDX_CONFIG, 16'h2600 | 16'(a << 5));
         rd(`TCS_IDX_CONFIG, 16'h0600 | 16'(a << 5));
         rd(`TCS_IDX_RESULT, v);
      end
      w = v;
      v = rnd();
      adc_sample <= v;
      wr(`TCS_IDX_CONFIG, 16'h0A20);
      repeat (30) @(posedge clk_sys);
      wr(`TCS_IDX_CONFIG, 16'h0620);
      wait_dr(120);
      cmp("abort flag", 16'h0000, {15'h0000, data_ready});
      rd(`TCS_IDX_RESULT, w);
      wr(`TCS_IDX_CONFIG, 16'h0000);
      wait_dr(40);
      t1 = cyc;
      rd(`TCS_IDX_RESULT, v);
      v = rnd();
      adc_sample <= v;
      // one-shot request outside shutdown is refused
      wr(`TCS_IDX_CONFIG, 16'h0800);
      rd(`TCS_IDX_CONFIG, 16'h0000);
      wait_dr(16000);
      // code 0 cycle is 15.5 ms, one cycle per us here
      cmp("cycle period", 16'h3C8C, 16'(cyc - t1));
      rd(`TCS_IDX_RESULT, v);
      start <= 1'b1;
      repeat (40) @(posedge clk_sys);
      #1;
      cmp("data drive", 16'h0000, {15'h0000, sda_oe_n});
      cmp("data level", 16'h0000, {15'h0000, sda_o});
      stall <= 1'b1;
      repeat (44) @(posedge clk_sys);
      #1;
      cmp("early release", 16'h0000, {15'h0000, sda_oe_n});
      repeat (14) @(posedge clk_sys);
      #1;
      cmp("stall release", 16'h0001, {15'h0000, sda_oe_n});
      start <= 1'b0;
      stall <= 1'b0;
      repeat (8) @(posedge clk_sys);
      start <= 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
      cmp("drive again", 16'h0000, {15'h0000, sda_oe_n});
      start <= 1'b0;
      @(posedge clk_sys);
      halt_strap <= 1'b1;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      wait_dr(200);
      cmp("strap flag", 16'h0000, {15'h0000, data_ready});
      rd(`TCS_IDX_CONFIG, 16'h0620);
      rd(`TCS_IDX_RESULT, `TCS_RESULT_RST);
      repeat (2) @(posedge clk_sys);
      give_verdict();
   end
endmodule
